// File: src/esa_map.vh
// Behaviour
// - at power-up copy configuration nonvolatile bytes into shadow RAM first
// - user nonvolatile region has no shadow copy, never recalled
// - eeprom_select high steers host reads and writes to nonvolatile array
// - eeprom_select low steers host reads and writes to shadow RAM
// - device configuration outputs come from shadow RAM only
// - single-byte and sequential multi-byte reads of both memories
// - clean nonvolatile read returns data, clears both correction flags
// - single-bit error corrected, data correct, corrected_flag set
// - double error sets uncorrectable_flag, corrected_flag 0, data invalid
// - recall corrects single errors; double error keeps old shadow byte
// - recall enables normal operation without checking correction flags
// - flags clear on next valid read, no power-up record kept; recall_bad_q still latches recall double errors but is never read
// - split serial data in and out pins act as one line when tied
// - slave address chosen by level on address-select pin
// - device is slave only; master starts transfers and clocks
// - bytes shift most significant bit first, bit 7 leading
// - data changes only while clock low except start and stop
// - every command begins with start: data falls while clock high
// - bus activity ignored until a start condition is seen
// - host memory access goes through the serial slave port; cfg_addr reads shadow RAM directly
// - stop: data rises while clock high, returns device to standby
// - receiver drives data low on ninth clock to acknowledge
`ifndef ESA_MAP_VH
`define ESA_MAP_VH
// ----------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------
`define ESA_MEM_WORDS     256
`define ESA_CFG_LAST      8'h57
`define ESA_USER_FIRST    8'h50
`define ESA_PAGE_MASK     8'h03
`define ESA_SELECT_ADDR   8'h89
`define ESA_SELECT_BIT    0
`define ESA_FLAG_ADDR     8'h8a
`define ESA_FLAG_CORR_BIT 0
`define ESA_FLAG_UNC_BIT  1
// ----------------------------------------------------------------
// slave address
// ----------------------------------------------------------------
`define ESA_SLAVE_BASE    7'h28
`define ESA_SLAVE_ALT     7'h29
// ----------------------------------------------------------------
// codeword layout: data in [7:0], check bits [12:8]
// ----------------------------------------------------------------
`define ESA_CW_W          13
`define ESA_CHK_W         5
`endif

// File: src/esa_ecc_enc.v
`include "esa_map.vh"
// sec-ded encoder: hamming 4 bits plus overall parity
module esa_ecc_enc (
	input  wire [7:0]               data,
	output wire [`ESA_CW_W-1:0]     code
);
	wire [3:0] h;
	assign h[0] = data[0] ^ data[1] ^ data[3] ^ data[4] ^ data[6];
	assign h[1] = data[0] ^ data[2] ^ data[3] ^ data[5] ^ data[6];
	assign h[2] = data[1] ^ data[2] ^ data[3] ^ data[7];
	assign h[3] = data[4] ^ data[5] ^ data[6] ^ data[7];
	// overall parity over data and hamming bits gives double detection
	assign code = {^{h, data}, h, data};
endmodule // esa_ecc_enc

// File: src/esa_ecc_dec.v
`include "esa_map.vh"
// sec-ded decoder: corrects one bit, flags two
module esa_ecc_dec (
	input  wire [`ESA_CW_W-1:0] code,
	output reg  [7:0]           data,
	output reg                  corr,
	output reg                  unc
);
	wire [7:0] d;
	wire [3:0] s;
	wire       p;
	assign d = code[7:0];
	assign s[0] = code[8] ^ d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
	assign s[1] = code[9] ^ d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
	assign s[2] = code[10] ^ d[1] ^ d[2] ^ d[3] ^ d[7];
	assign s[3] = code[11] ^ d[4] ^ d[5] ^ d[6] ^ d[7];
	assign p = ^code;
	// syndrome maps to data bit; check-bit hits leave data alone
	always @* begin
		data = d;
		corr = 1'b0;
		unc  = 1'b0;
		if (s != 4'h0 && !p) begin
			unc = 1'b1;
		end else if (p) begin
			corr = 1'b1;
			case (s)
				4'h3: data[0] = ~d[0];
				4'h5: data[1] = ~d[1];
				4'h6: data[2] = ~d[2];
				4'h7: data[3] = ~d[3];
				4'h9: data[4] = ~d[4];
				4'ha: data[5] = ~d[5];
				4'hb: data[6] = ~d[6];
				4'hc: data[7] = ~d[7];
				default: data = d;
			endcase
		end
	end
endmodule // esa_ecc_dec

// File: src/esa_top.v
`include "esa_map.vh"
module esa_top #(
	parameter AW = 8
) (
	input  wire          clk_sys,
	input  wire          rstn,
	input  wire          serial_clock,
	input  wire          serial_data_in,
	input  wire          addr_select,
	output reg           serial_data_out,
	output reg           serial_data_oe,
	output reg           ready_q,
	output reg           eeprom_select_q,
	output reg           corrected_flag_q,
	output reg           uncorrectable_flag_q,
	output reg  [7:0]    cfg_byte_q,
	input  wire [AW-1:0] cfg_addr
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	reg [`ESA_CW_W-1:0] nv_mem [0:`ESA_MEM_WORDS-1];
	reg [7:0]           sh_mem [0:`ESA_MEM_WORDS-1];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [1:0] scl_s_q;
	reg [1:0] sda_s_q;
	reg [1:0] asel_s_q;
	reg       scl_q;
	reg       sda_q;
	// two flops per pin; second stage feeds logic, a third flop on clock and data finds edges
	always @(posedge clk_sys) begin
		if (!rstn) begin
			scl_s_q  <= 2'b11;
			sda_s_q  <= 2'b11;
			asel_s_q <= 2'b00;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_s_q  <= {scl_s_q[0], serial_clock};
			sda_s_q  <= {sda_s_q[0], serial_data_in};
			asel_s_q <= {asel_s_q[0], addr_select};
			scl_q    <= scl_s_q[1];
			sda_q    <= sda_s_q[1];
		end
	end
	wire scl = scl_s_q[1];
	wire sda = sda_s_q[1];
	wire scl_rise = scl & ~scl_q;
	wire scl_fall = ~scl & scl_q;
	wire start_ev = scl & scl_q & sda_q & ~sda;
	wire stop_ev  = scl & scl_q & ~sda_q & sda;
	// address follows the select pin
	wire [6:0] my_addr = asel_s_q[1] ? `ESA_SLAVE_ALT : `ESA_SLAVE_BASE;

	// ----------------------------------------------------------------
	// ecc datapath
	// ----------------------------------------------------------------
	reg  [7:0]          rx_q;
	wire [`ESA_CW_W-1:0] enc_code;
	wire [7:0]          dec_data;
	wire                dec_corr;
	wire                dec_unc;
	reg  [AW-1:0]       ptr_q;
	reg  [AW-1:0]       rc_q;
	wire [AW-1:0]       nv_idx = ready_q ? ptr_q : rc_q;
	wire [`ESA_CW_W-1:0] nv_rd = nv_mem[nv_idx];

	esa_ecc_enc u_enc (
		.data (rx_q),
		.code (enc_code)
	);
	esa_ecc_dec u_dec (
		.code (nv_rd),
		.data (dec_data),
		.corr (dec_corr),
		.unc  (dec_unc)
	);

	// ----------------------------------------------------------------
	// power-up recall
	// ----------------------------------------------------------------
	reg recall_bad_q;
	// walks through ESA_CFG_LAST but copies only below ESA_USER_FIRST; user bytes stay unshadowed
	always @(posedge clk_sys) begin
		if (!rstn) begin
			rc_q         <= {AW{1'b0}};
			ready_q      <= 1'b0;
			recall_bad_q <= 1'b0;
		end else if (!ready_q) begin
			if (rc_q < `ESA_USER_FIRST) begin
				if (!dec_unc)
					sh_mem[rc_q] <= dec_data;
				recall_bad_q <= recall_bad_q | dec_unc;
			end
			if (rc_q == `ESA_CFG_LAST)
				ready_q <= 1'b1;
			rc_q <= rc_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// serial slave state machine
	// ----------------------------------------------------------------
	localparam S_IDLE = 3'd0;
	localparam S_DEV  = 3'd1;
	localparam S_WADR = 3'd2;
	localparam S_WDAT = 3'd3;
	localparam S_RD   = 3'd4;
	localparam S_ACK  = 3'd5;
	localparam S_MACK = 3'd6;

	reg [2:0] st_q;
	reg [2:0] nxt_q;
	reg [3:0] bit_q;
	reg [7:0] tx_q;
	reg       drive_q;

	// read source: eeprom_select chooses the memory
	wire [7:0] rd_byte = eeprom_select_q ? dec_data : sh_mem[ptr_q];
	// page write wraps inside its four-byte page
	wire [AW-1:0] page_inc = (ptr_q & ~`ESA_PAGE_MASK) |
		((ptr_q + 1'b1) & `ESA_PAGE_MASK);

	// ignores traffic until start, stop returns to idle
	// the only path into either memory from outside
	always @(posedge clk_sys) begin
		if (!rstn) begin
			st_q                 <= S_IDLE;
			nxt_q                <= S_IDLE;
			bit_q                <= 4'h0;
			rx_q                 <= 8'h00;
			tx_q                 <= 8'hff;
			drive_q              <= 1'b0;
			ptr_q                <= {AW{1'b0}};
			eeprom_select_q      <= 1'b0;
			corrected_flag_q     <= 1'b0;
			uncorrectable_flag_q <= 1'b0;
		end else if (!ready_q) begin
			st_q <= S_IDLE;
		end else if (start_ev) begin
			st_q    <= S_DEV;
			bit_q   <= 4'h0;
			drive_q <= 1'b0;
		end else if (stop_ev) begin
			st_q    <= S_IDLE;
			drive_q <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: drive_q <= 1'b0;
				S_DEV, S_WADR, S_WDAT: begin
					if (scl_rise) begin
						rx_q  <= {rx_q[6:0], sda};
						bit_q <= bit_q + 4'h1;
					end
					if (scl_fall && bit_q == 4'h8) begin
						bit_q <= 4'h0;
						if (st_q == S_DEV) begin
							if (rx_q[7:1] == my_addr) begin
								drive_q <= 1'b1;
								st_q    <= S_ACK;
								nxt_q   <= rx_q[0] ? S_RD : S_WADR;
							end else begin
								st_q <= S_IDLE;
							end
						end else if (st_q == S_WADR) begin
							ptr_q   <= rx_q;
							drive_q <= 1'b1;
							st_q    <= S_ACK;
							nxt_q   <= S_WDAT;
						end else begin
							if (ptr_q == `ESA_SELECT_ADDR)
								eeprom_select_q <= rx_q[`ESA_SELECT_BIT];
							else if (eeprom_select_q)
								nv_mem[ptr_q] <= enc_code;
							else
								sh_mem[ptr_q] <= rx_q;
							ptr_q   <= page_inc;
							drive_q <= 1'b1;
							st_q    <= S_ACK;
							nxt_q   <= S_WDAT;
						end
					end
				end
				S_ACK: begin
					// release after the ninth clock low phase begins
					if (scl_fall) begin
						drive_q <= 1'b0;
						bit_q   <= 4'h0;
						st_q    <= nxt_q;
						if (nxt_q == S_RD) begin
							tx_q    <= {rd_byte[6:0], 1'b1};
							drive_q <= ~rd_byte[7];
							bit_q   <= 4'h1;
							if (eeprom_select_q) begin
								corrected_flag_q <= dec_corr;
								uncorrectable_flag_q <= dec_unc;
							end
							ptr_q <= ptr_q + 1'b1;
						end
					end
				end
				S_RD: begin
					// shift on falling clock so data moves only while low
					if (scl_fall) begin
						if (bit_q == 4'h8) begin
							drive_q <= 1'b0;
							st_q    <= S_MACK;
						end else begin
							drive_q <= ~tx_q[7];
							tx_q    <= {tx_q[6:0], 1'b1};
							bit_q   <= bit_q + 4'h1;
						end
					end
				end
				S_MACK: begin
					// master ack continues a sequential read
					if (scl_rise) begin
						st_q <= sda ? S_IDLE : S_ACK;
						nxt_q <= S_RD;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drive and configuration view
	// ----------------------------------------------------------------
	// open-drain: output held low, enable pulls; tied pins work
	always @(posedge clk_sys) begin
		if (!rstn) begin
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
			cfg_byte_q      <= 8'h00;
		end else begin
			serial_data_out <= 1'b0;
			serial_data_oe  <= drive_q & (st_q != S_IDLE) & ~start_ev;
			cfg_byte_q      <= ready_q ? sh_mem[cfg_addr] : 8'h00;
		end
	end
endmodule // esa_top

// File: verif/esa_props.sv
// ----------------------------------------------------------------
// port checker for the eeprom shadow access block
// ----------------------------------------------------------------
module esa_props #(
	parameter AW = 8
) (
	input wire          clk_sys,
	input wire          rstn,
	input wire          serial_clock,
	input wire          serial_data_in,
	input wire          addr_select,
	input wire          serial_data_out,
	input wire          serial_data_oe,
	input wire          ready_q,
	input wire          eeprom_select_q,
	input wire          corrected_flag_q,
	input wire          uncorrectable_flag_q,
	input wire [7:0]    cfg_byte_q,
	input wire [AW-1:0] cfg_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// recall walks 0x58 locations, bound leaves slack
	sequence s_recall;
		##[1:200] ready_q;
	endsequence
	sequence s_quiet;
		!serial_data_oe && (cfg_byte_q == 8'h00);
	endsequence
	a_ready_bound: assert property ($rose(rstn) |-> s_recall)
		else $error("recall did not finish in time");
	a_quiet_unready: assert property (!ready_q |-> s_quiet)
		else $error("activity before recall finished");
	a_ready_holds: assert property (ready_q |=> ready_q)
		else $error("ready dropped");
	a_pull_only: assert property (serial_data_oe |-> !serial_data_out)
		else $error("data pin driven high");
	a_flags_excl: assert property (!(corrected_flag_q && uncorrectable_flag_q))
		else $error("both correction flags set");
	a_select_bus: assert property ($changed(eeprom_select_q) |-> ready_q)
		else $error("select moved without bus access");
	a_flags_array: assert property ($rose(corrected_flag_q) |-> eeprom_select_q)
		else $error("corrected flag from shadow read");
	a_unc_array: assert property ($rose(uncorrectable_flag_q) |-> eeprom_select_q)
		else $error("uncorrectable flag from shadow read");
endmodule // esa_props

// File: verif/esa_i2c_master.sv
// ----------------------------------------------------------------
// two-wire bus master, steps aligned just after the clock edge
// ----------------------------------------------------------------
module esa_i2c_master (
	input  wire  clk_sys,
	input  wire  serial_data_oe,
	input  wire  serial_data_out,
	output logic serial_clock,
	output wire  serial_data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic m_sda = 1'b1;
	initial serial_clock = 1'b1;
	// pulled-up line: a low driver wins, released reads high
	assign serial_data_in = (serial_data_oe && !serial_data_out) ? 1'b0 : m_sda;
	// quarter bit: four make a 160 ns clock
	task automatic q;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// one clock pulse, sampled mid-high
	task automatic pulse(output logic s);
		q;
		serial_clock = 1'b1;
		q;
		s = serial_data_in;
		q;
		serial_clock = 1'b0;
	endtask
	// extra low time lets an ack drive end first
	task automatic start;
		q;
		q;
		m_sda = 1'b1;
		q;
		serial_clock = 1'b1;
		q;
		m_sda = 1'b0;
		q;
		serial_clock = 1'b0;
	endtask
	task automatic stop;
		q;
		m_sda = 1'b0;
		q;
		serial_clock = 1'b1;
		q;
		m_sda = 1'b1;
		q;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin // msb first, low clock
			q;
			m_sda = b[i];
			pulse(s);
		end
		q;
		m_sda = 1'b1; // released for the ack
		pulse(s);
		ack = !s;
		q;
		q;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 0; i < 8; i++) begin
			q;
			m_sda = 1'b1;
			pulse(s);
			b = {b[6:0], s};
		end
		q;
		m_sda = !more; // ack asks for more, nack ends
		pulse(s);
		q;
		m_sda = 1'b1;
	endtask
endmodule // esa_i2c_master

// File: verif/eeprom_shadow_i2c_access_tb.sv
`include "esa_map.vh"
module eeprom_shadow_i2c_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys;
	logic       rstn;
	logic       addr_select;
	logic [7:0] cfg_addr;
	wire        scl, sdi, sdo, oe, rdy, sel, corr, unc;
	wire  [7:0] cfg_byte;
	int         error_cnt = 0;
	int         check_count = 0;
	int         cyc = 0;
	esa_top #(.AW(8)) DUT (.clk_sys(clk_sys), .rstn(rstn), .serial_clock(scl),
		.serial_data_in(sdi), .addr_select(addr_select),
		.serial_data_out(sdo), .serial_data_oe(oe), .ready_q(rdy),
		.eeprom_select_q(sel), .corrected_flag_q(corr),
		.uncorrectable_flag_q(unc), .cfg_byte_q(cfg_byte), .cfg_addr(cfg_addr));
	esa_i2c_master m (.clk_sys(clk_sys), .serial_data_oe(oe),
		.serial_data_out(sdo), .serial_clock(scl), .serial_data_in(sdi));
	// ----------------------------------------------------------------
	// clock, hang guard, reporting
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// tests need some 5200 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [6:0] sa;
		sa = addr_select ? `ESA_SLAVE_ALT : `ESA_SLAVE_BASE;
	endfunction
	// ----------------------------------------------------------------
	// bus transfers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
		logic k;
		m.start;
		m.wbyte({sa(), 1'b0}, k);
		chk8({7'h00, k}, 8'h01);
		m.wbyte(a, k);
		for (int i = 0; i < n; i++)
			m.wbyte(d[31-8*i -: 8], k);
		m.stop;
	endtask
	task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d);
		logic       k;
		logic [7:0] b;
		d = 32'h0;
		m.start;
		m.wbyte({sa(), 1'b0}, k);
		m.wbyte(a, k);
		m.start;
		m.wbyte({sa(), 1'b1}, k);
		chk8({7'h00, k}, 8'h01);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i < n - 1, b);
			d = {d[23:0], b};
		end
		m.stop;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_recall;
		for (int w = 0; w < 400 && rdy !== 1'b1; w++)
			@(posedge clk_sys);
		#1;
		chk8({7'h00, rdy}, 8'h01);
		chk8({6'h00, corr, unc}, 8'h00);
		$display("test recall done");
	endtask
	task automatic t_shadow;
		logic [31:0] d;
		wr(8'h10, 32'h5a000000, 1);
		cfg_addr = 8'h10;
		repeat (2) @(posedge clk_sys);
		#1;
		chk8(cfg_byte, 8'h5a);
		wr(8'h11, 32'hc3000000, 1);
		rd(8'h10, 2, d);
		chk8(d[15:8], 8'h5a);
		chk8(d[7:0], 8'hc3);
		chk8({6'h00, corr, unc}, 8'h00);
		$display("test shadow done");
	endtask
	task automatic t_addr;
		logic        k;
		logic [31:0] d;
		m.start;
		m.wbyte({`ESA_SLAVE_ALT, 1'b0}, k);
		chk8({7'h00, k}, 8'h00);
		m.stop;
		addr_select = 1'b1;
		rd(8'h10, 1, d);
		chk8(d[7:0], 8'h5a);
		addr_select = 1'b0;
		$display("test address done");
	endtask
	task automatic t_array;
		logic [31:0] d;
		wr(`ESA_SELECT_ADDR, 32'h01000000, 1);
		chk8({7'h00, sel}, 8'h01);
		// page from location 2 wraps to 0 and 1
		wr(8'h52, 32'h11223344, 4);
		rd(8'h50, 4, d);
		for (int i = 0; i < 4; i++)
			chk8(d[31-8*i -: 8], 8'h33 + 8'h11 * i[7:0] - (i > 1 ? 8'h44 : 8'h00));
		chk8({6'h00, corr, unc}, 8'h00);
		chk8(cfg_byte, 8'h5a);
		wr(`ESA_SELECT_ADDR, 32'h0, 1);
		rd(8'h10, 1, d);
		chk8(d[7:0], 8'h5a);
		$display("test array done");
	endtask
	// corrupt stored codewords to reach the correction paths
	task automatic t_ecc;
		logic [31:0] d;
		wr(`ESA_SELECT_ADDR, 32'h01000000, 1);
		wr(8'h54, 32'ha5c30f96, 4);
		DUT.nv_mem[8'h54] = DUT.nv_mem[8'h54] ^ 13'h0001;
		rd(8'h54, 1, d);
		chk8(d[7:0], 8'ha5);
		chk8({6'h00, corr, unc}, 8'h02);
		DUT.nv_mem[8'h55] = DUT.nv_mem[8'h55] ^ 13'h0003;
		rd(8'h55, 1, d);
		chk8({6'h00, corr, unc}, 8'h01);
		rd(8'h56, 1, d);
		chk8(d[7:0], 8'h0f);
		chk8({6'h00, corr, unc}, 8'h00);
		wr(`ESA_SELECT_ADDR, 32'h0, 1);
		chk8({7'h00, sel}, 8'h00);
		$display("test ecc done");
	endtask
	initial begin
		rstn = 1'b0;
		addr_select = 1'b0;
		cfg_addr = 8'h00;
		repeat (2) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		t_recall;
		t_shadow;
		t_addr;
		t_array;
		t_ecc;
		wrap_up;
	end
endmodule // eeprom_shadow_i2c_access_tb
bind esa_top esa_props #(.AW(AW)) u_props (.clk_sys(clk_sys), .rstn(rstn),
	.serial_clock(serial_clock), .serial_data_in(serial_data_in),
	.addr_select(addr_select), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .ready_q(ready_q),
	.eeprom_select_q(eeprom_select_q), .corrected_flag_q(corrected_flag_q),
	.uncorrectable_flag_q(uncorrectable_flag_q), .cfg_byte_q(cfg_byte_q),
	.cfg_addr(cfg_addr));
